// [core/padec_top.v]
// Programmable address decoder producing internal and external chip selects.
`timescale 1ns/10ps
`include "padec_defs.vh"
module padec_top #(
   parameter N_TERMS = `PADEC_NTERMS,
   parameter N_IN    = `PADEC_NIN
) (
   input  wire                    i_clk,
   input  wire                    i_rst,
   // Host bus.
   input  wire [4:0]              i_addr_hi,
   input  wire                    i_high_address_or_powerdown,
   input  wire                    i_address_latch_strobe,
   input  wire                    i_read_strobe,
   input  wire                    i_write_strobe,
   input  wire [7:0]              i_low_address_data_bus,
   output reg  [7:0]              o_low_address_data_bus,
   output reg                     o_low_address_data_bus_oe_n,
   input  wire [3:0]              i_page_bits,
   // Configuration held in non-volatile cells outside this block.
   input  wire [N_TERMS*N_IN-1:0] i_cfg_care,
   input  wire [N_TERMS*N_IN-1:0] i_cfg_value,
   input  wire [N_TERMS-1:0]      i_cfg_term_en,
   input  wire                    i_cfg_use_powerdown,
   input  wire                    i_cfg_rw_select,
   input  wire                    i_cfg_track_mode,
   input  wire [7:0]              i_cfg_portb_route,
   input  wire [2:0]              i_cfg_portc_route,
   // Internal selects, active high.
   output reg  [7:0]              o_program_bank_selects,
   output reg                     o_sram_select,
   output reg                     o_port_space_select,
   output reg                     o_track_read_select,
   output reg                     o_track_address_out_select,
   output reg                     o_track_write_out_select,
   // External selects, active low.
   output reg  [3:0]              o_wide_external_selects_n,
   output reg  [3:0]              o_mid_external_selects_n,
   output reg  [2:0]              o_narrow_external_selects_n,
   // Port pins.
   input  wire [7:0]              i_port_a,
   output reg  [7:0]              o_port_a,
   output reg                     o_port_a_oe_n,
   output reg  [7:0]              o_port_b,
   output reg  [7:0]              o_port_b_oe_n,
   input  wire [2:0]              i_port_c,
   output reg  [2:0]              o_port_c,
   output reg  [2:0]              o_port_c_oe_n,
   output reg  [7:0]              o_latched_address
);

   wire [N_IN-1:0]    dec_in;
   wire [N_TERMS-1:0] term;
   wire               deselect;
   wire               rd_int;
   wire               wr_int;
   reg  [2:0]         high_addr;
   reg  [3:0]         wide_sel;
   reg  [3:0]         mid_sel;
   reg                track_ao;
   reg                track_wo;
   reg                track_rd;
   reg                ale_d1_q;
   wire               ale_d1_d;
   reg  [7:0]         laddr_q;
   reg  [7:0]         laddr_d;
   integer            k;
   integer            n;

   // OR of a group of consecutive terms starting at a given index.
   function group_or;
      input [N_TERMS-1:0] terms;
      input integer       base;
      input integer       width;
      integer             j;
      begin
         group_or = 1'b0;
         for (j = 0; j < width; j = j + 1) begin
            group_or = group_or | terms[base+j];
         end
      end
   endfunction

   // Internal strobes in the two bus styles: pulse pins, or enable plus read/write.
   assign rd_int = i_cfg_rw_select ? (i_read_strobe & i_write_strobe) : ~i_read_strobe;
   assign wr_int = i_cfg_rw_select ? (i_read_strobe & ~i_write_strobe) : ~i_write_strobe;

   // Power-down only applies when the shared pin is configured for it.
   assign deselect = i_rst | (i_cfg_use_powerdown & i_high_address_or_powerdown);

   // Port C pins feed the decoder as high address only where they are inputs.
   always @* begin
      for (n = 0; n < 3; n = n + 1) begin
         high_addr[n] = i_cfg_portc_route[n] ? 1'b0 : i_port_c[n];
      end
   end

   // One vector feeds the product-term array; reset is deliberately not part of it.
   assign dec_in[`PADEC_IN_ADDR_LO +: `PADEC_IN_ADDR_W]   = i_addr_hi;
   assign dec_in[`PADEC_IN_HADDR_LO +: `PADEC_IN_HADDR_W] = high_addr;
   assign dec_in[`PADEC_IN_A19]  = i_cfg_use_powerdown ? 1'b0 : i_high_address_or_powerdown;
   assign dec_in[`PADEC_IN_PAGE_LO +: `PADEC_IN_PAGE_W]   = i_page_bits;
   assign dec_in[`PADEC_IN_RD]   = i_read_strobe;
   assign dec_in[`PADEC_IN_WR]   = i_write_strobe;
   assign dec_in[`PADEC_IN_ALE]  = i_address_latch_strobe;

   padec_pterm #(
      .N_TERMS (N_TERMS),
      .N_IN    (N_IN)
   ) u_pterm (
      .i_in      (dec_in),
      .i_care    (i_cfg_care),
      .i_value   (i_cfg_value),
      .i_term_en (i_cfg_term_en),
      .o_term    (term)
   );

   // Second array: OR groups for the wide and mid selects.
   always @* begin
      for (k = 0; k < `PADEC_N_WIDE; k = k + 1) begin
         wide_sel[k] = group_or(term, `PADEC_T_WIDE + k*`PADEC_W_WIDE, `PADEC_W_WIDE);
      end
      for (k = 0; k < `PADEC_N_MID; k = k + 1) begin
         mid_sel[k] = group_or(term, `PADEC_T_MID + k*`PADEC_W_MID, `PADEC_W_MID);
      end
   end

   // Selects stay combinational so a decode is valid in the same bus cycle.
   always @* begin
      o_program_bank_selects      = deselect ? 8'h00 :
                                    term[`PADEC_T_BANK +: `PADEC_N_BANK];
      o_sram_select               = ~deselect & term[`PADEC_T_SRAM];
      o_port_space_select         = ~deselect & term[`PADEC_T_PORT];
      o_track_read_select         = ~deselect & term[`PADEC_T_TRK_RD];
      o_track_address_out_select  = ~deselect & term[`PADEC_T_TRK_AO];
      o_track_write_out_select    = ~deselect & term[`PADEC_T_TRK_WO];
      o_wide_external_selects_n   = deselect ? 4'hF : ~wide_sel;
      o_mid_external_selects_n    = deselect ? 4'hF : ~mid_sel;
      o_narrow_external_selects_n = deselect ? 3'h7 :
                                    ~term[`PADEC_T_NARROW +: `PADEC_N_NARROW];
   end

   // Track mode buffering. The write-out term is trusted to carry write qualification.
   always @* begin
      track_ao = i_cfg_track_mode & o_track_address_out_select & i_address_latch_strobe;
      track_wo = i_cfg_track_mode & o_track_write_out_select & ~track_ao;
      track_rd = i_cfg_track_mode & o_track_read_select & rd_int & ~track_ao & ~track_wo;
   end

   // Port A and the low bus never drive toward each other at once.
   always @* begin
      o_port_a                    = i_low_address_data_bus;
      o_port_a_oe_n               = ~(track_ao | track_wo);
      o_low_address_data_bus      = i_port_a;
      o_low_address_data_bus_oe_n = ~track_rd;
   end

   // Port B and C pins carry a select only where routed; elsewhere they float.
   always @* begin
      o_port_b      = {o_mid_external_selects_n, o_wide_external_selects_n};
      o_port_b_oe_n = ~i_cfg_portb_route;
      o_port_c      = o_narrow_external_selects_n;
      o_port_c_oe_n = ~i_cfg_portc_route;
   end

   // Address latch: transparent while the strobe is high, holds after its fall.
   assign ale_d1_d = i_address_latch_strobe;

   always @* begin
      laddr_d = laddr_q;
      if (i_address_latch_strobe) begin
         laddr_d = i_low_address_data_bus;
      end
   end

   always @(posedge i_clk) begin
      if (i_rst) begin
         ale_d1_q <= 1'b0;
         laddr_q  <= `PADEC_LADDR_RST;
      end else begin
         ale_d1_q <= ale_d1_d;
         laddr_q  <= laddr_d;
      end
   end

   // The latched copy is published only once the strobe has fallen.
   always @(posedge i_clk) begin
      if (i_rst) begin
         o_latched_address <= `PADEC_LADDR_RST;
      end else if (ale_d1_q & ~i_address_latch_strobe) begin
         o_latched_address <= laddr_q;
      end
   end

endmodule // padec_top

// [pkg/padec_defs.vh]
// Constants for the programmable address decoder: input vector layout and term map.
`ifndef PADEC_DEFS_VH
`define PADEC_DEFS_VH

// Product-term input vector, bit positions.
`define PADEC_IN_ADDR_LO   0
`define PADEC_IN_ADDR_W    5
`define PADEC_IN_HADDR_LO  5
`define PADEC_IN_HADDR_W   3
`define PADEC_IN_A19       8
`define PADEC_IN_PAGE_LO   9
`define PADEC_IN_PAGE_W    4
`define PADEC_IN_RD        13
`define PADEC_IN_WR        14
`define PADEC_IN_ALE       15
`define PADEC_NIN          16

// Product-term map, first index of each group.
`define PADEC_T_BANK       0
`define PADEC_N_BANK       8
`define PADEC_T_SRAM       8
`define PADEC_T_PORT       9
`define PADEC_T_TRK_RD     10
`define PADEC_T_TRK_AO     11
`define PADEC_T_TRK_WO     12
`define PADEC_T_WIDE       13
`define PADEC_N_WIDE       4
`define PADEC_W_WIDE       4
`define PADEC_T_MID        29
`define PADEC_N_MID        4
`define PADEC_W_MID        2
`define PADEC_T_NARROW     37
`define PADEC_N_NARROW     3
`define PADEC_NTERMS       40

// Reset value of the latched low address.
`define PADEC_LADDR_RST    8'h00

`endif

// [core/padec_pterm.v]
// Array of configurable product terms over a shared input vector.
`timescale 1ns/10ps
module padec_pterm #(
   parameter N_TERMS = 40,
   parameter N_IN    = 16
) (
   input  wire [N_IN-1:0]         i_in,
   input  wire [N_TERMS*N_IN-1:0] i_care,
   input  wire [N_TERMS*N_IN-1:0] i_value,
   input  wire [N_TERMS-1:0]      i_term_en,
   output wire [N_TERMS-1:0]      o_term
);

   // A literal takes part only where its care bit is set; the term must still be enabled.
   function term_match;
      input [N_IN-1:0] in;
      input [N_IN-1:0] care;
      input [N_IN-1:0] value;
      input            en;
      begin
         term_match = en & (&(~care | ~(in ^ value)));
      end
   endfunction

   genvar t;
   generate
      for (t = 0; t < N_TERMS; t = t + 1) begin : g_term
         assign o_term[t] = term_match(i_in, i_care[t*N_IN +: N_IN],
                                       i_value[t*N_IN +: N_IN], i_term_en[t]);
      end
   endgenerate

endmodule // padec_pterm

// [test/padec_sva.sv]
// Checker for decoder deselect, track buffer direction and the address latch.
`timescale 1ns/10ps
module padec_sva (
   input wire logic       i_clk,
   input wire logic       i_rst,
   input wire logic       i_high_address_or_powerdown,
   input wire logic       i_address_latch_strobe,
   input wire logic       i_read_strobe,
   input wire logic [7:0] i_low_address_data_bus,
   input wire logic [7:0] o_low_address_data_bus,
   input wire logic       o_low_address_data_bus_oe_n,
   input wire logic       i_cfg_use_powerdown,
   input wire logic       i_cfg_rw_select,
   input wire logic       i_cfg_track_mode,
   input wire logic [7:0] o_program_bank_selects,
   input wire logic       o_track_read_select,
   input wire logic       o_track_address_out_select,
   input wire logic       o_track_write_out_select,
   input wire logic [3:0] o_wide_external_selects_n,
   input wire logic [7:0] i_port_a,
   input wire logic [7:0] o_port_a,
   input wire logic       o_port_a_oe_n,
   input wire logic [7:0] o_latched_address
);
   wire idle = o_program_bank_selects == 8'h00 && &o_wide_external_selects_n && o_port_a_oe_n
      && o_low_address_data_bus_oe_n && !o_track_read_select && !o_track_address_out_select && !o_track_write_out_select;
   wire ao = i_cfg_track_mode && o_track_address_out_select && i_address_latch_strobe;
   wire wo = i_cfg_track_mode && o_track_write_out_select;
   // Only the read-pin option is judged, so the strobe-and-select option cannot raise false alarms.
   wire rd = i_cfg_track_mode && !i_cfg_rw_select && o_track_read_select && !i_read_strobe;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence s_fall; i_address_latch_strobe ##1 !i_address_latch_strobe; endsequence
   sequence s_low2; !i_address_latch_strobe ##1 !i_address_latch_strobe; endsequence
   property p_rst; $fell(i_rst) |-> $past(idle); endproperty
   a_rst: assert property (p_rst) else $error("select active in reset");
   property p_pd; i_cfg_use_powerdown && i_high_address_or_powerdown |-> idle; endproperty
   a_pd: assert property (p_pd) else $error("select active in standby");
   property p_latch; s_fall |=> o_latched_address == $past(i_low_address_data_bus, 2); endproperty
   a_latch: assert property (p_latch) else $error("latched address wrong");
   property p_hold; s_low2 |=> $stable(o_latched_address); endproperty
   a_hold: assert property (p_hold) else $error("latched address moved");
   property p_ao; ao |-> !o_port_a_oe_n && o_port_a == i_low_address_data_bus; endproperty
   a_ao: assert property (p_ao) else $error("address not out on port a");
   property p_wo; wo && !ao |-> !o_port_a_oe_n && o_port_a == i_low_address_data_bus; endproperty
   a_wo: assert property (p_wo) else $error("data not out on port a");
   property p_rd; rd && !ao && !wo |-> !o_low_address_data_bus_oe_n && o_low_address_data_bus == i_port_a; endproperty
   a_rd: assert property (p_rd) else $error("port a not on low bus");
   property p_off; i_cfg_track_mode && !i_cfg_rw_select && !ao && !wo && !rd |-> o_port_a_oe_n; endproperty
   a_off: assert property (p_off) else $error("port a driven when idle");
endmodule // padec_sva
bind padec_top padec_sva u_sva (.*);

// [test/padec_host.sv]
// Host bus model driving address, page, strobes and the low bus.
`timescale 1ns/10ps
module padec_host (
   input  wire logic  i_clk,
   output logic [4:0] o_addr = 5'h00,
   output logic [3:0] o_page = 4'h0,
   output logic       o_ale = 1'h0,
   output logic       o_rd_n = 1'h1,
   output logic       o_wr_n = 1'h1,
   output logic [7:0] o_ad = 8'h00
);
   task automatic put(input logic [4:0] a, input logic [3:0] p, input logic [2:0] c, input logic [7:0] d);
      @(posedge i_clk);
      #1;
      {o_addr, o_page} = {a, p};
      {o_ale, o_rd_n, o_wr_n} = c;
      // During a read the host drives the complement of its last value, so it shows no stale copy.
      o_ad = c[1] ? d : ~o_ad;
      #1;
   endtask
endmodule // padec_host

// [test/test_address_decode_chip_selects.sv]
// Self-checking bench for the address decoder and its track buffer.
`timescale 1ns/10ps
`include "padec_defs.vh"
module test_address_decode_chip_selects;
   localparam int NB = `PADEC_NTERMS * `PADEC_NIN;
   logic          i_clk = 1'h0, i_rst = 1'h1, i_high_address_or_powerdown = 1'h0;
   logic          i_cfg_use_powerdown = 1'h0, i_cfg_rw_select = 1'h0, i_cfg_track_mode = 1'h0;
   logic [NB-1:0] i_cfg_care = '0, i_cfg_value = '0;
   logic [39:0]   i_cfg_term_en = '0;
   logic [7:0]    i_port_a = 8'h96, i_cfg_portb_route = 8'hFF;
   logic [2:0]    i_port_c = 3'h0, i_cfg_portc_route = 3'h0;
   int            num_errors = 0, samples_checked = 0;
   wire  [7:0]    i_low_address_data_bus, o_low_address_data_bus, o_program_bank_selects, o_port_a, o_port_b;
   wire  [7:0]    o_port_b_oe_n, o_latched_address;
   wire  [4:0]    i_addr_hi;
   wire  [3:0]    i_page_bits, o_wide_external_selects_n, o_mid_external_selects_n;
   wire  [2:0]    o_narrow_external_selects_n, o_port_c, o_port_c_oe_n;
   wire           i_address_latch_strobe, i_read_strobe, i_write_strobe, o_low_address_data_bus_oe_n, o_sram_select;
   wire           o_port_space_select, o_track_read_select, o_track_address_out_select, o_track_write_out_select;
   wire           o_port_a_oe_n;
   padec_host host (.i_clk(i_clk), .o_addr(i_addr_hi), .o_page(i_page_bits), .o_ale(i_address_latch_strobe),
      .o_rd_n(i_read_strobe), .o_wr_n(i_write_strobe), .o_ad(i_low_address_data_bus));
   padec_top dut (.*);
   always #10 i_clk = ~i_clk;
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic term(input int t, input logic [15:0] c, input logic [15:0] v);
      i_cfg_care[t*16+:16] = c;
      i_cfg_value[t*16+:16] = v;
      i_cfg_term_en[t] = 1'h1;
   endtask
   function automatic logic [15:0] hot(input int a, input int d, input int n, input logic [15:0] m);
      return (a < 1 || a > n) ? m : m ^ (16'h1 << ((a - 1) / d));
   endfunction
   task automatic t_sel();
      i_cfg_term_en = '0;
      term(`PADEC_T_SRAM, 16'h1E00, 16'h1400);
      for (int k = 0; k < 8; k++) begin
         term(`PADEC_T_BANK + k, 16'h001F, 16'(k));
         term(`PADEC_T_WIDE + k, 16'h001F, 16'(k + 1));
         term(`PADEC_T_MID + k, 16'h001F, 16'(k + 1));
         term(`PADEC_T_NARROW + k % 3, 16'h001F, 16'(k % 3 + 1));
      end
      for (int a = 0; a < 10; a++) begin
         host.put(5'(a), 4'(a % 2 * 10), 3'h3, 8'h00);
         chk("bank", a < 8 ? 16'h1 << a : 16'h0, 16'(o_program_bank_selects));
         chk("sram", 16'(a % 2), 16'(o_sram_select));
         chk("wide", hot(a, 4, 8, 16'hF), 16'(o_wide_external_selects_n));
         chk("mid", hot(a, 2, 8, 16'hF), 16'(o_mid_external_selects_n));
         chk("narrow", hot(a, 1, 3, 16'h7), 16'(o_narrow_external_selects_n));
         chk("port b", {8'h00, 4'(hot(a, 2, 8, 16'hF)), 4'(hot(a, 4, 8, 16'hF))}, 16'(o_port_b));
         chk("port b oe", 16'h0000, 16'(o_port_b_oe_n));
         chk("port c", {5'h00, 3'(hot(a, 1, 3, 16'h7)), 5'h00, o_port_c_oe_n}, {5'h00, o_port_c, 8'h07});
      end
      $display("Select test done");
   endtask
   task automatic t_track();
      i_cfg_term_en = '0;
      i_cfg_track_mode = 1'h1;
      term(`PADEC_T_TRK_RD, 16'h001F, 16'h0003);
      term(`PADEC_T_TRK_AO, 16'h8000, 16'h8000);
      term(`PADEC_T_TRK_WO, 16'h4000, 16'h0000);
      host.put(5'h03, 4'h0, 3'h7, 8'h5A);
      chk("addr out", 16'h005A, {7'h00, o_port_a_oe_n, o_port_a});
      host.put(5'h03, 4'h0, 3'h2, 8'hC3);
      chk("write out", 16'h00C3, {7'h00, o_port_a_oe_n, o_port_a});
      host.put(5'h03, 4'h0, 3'h1, 8'h00);
      chk("read in", 16'h0096, {7'h00, o_low_address_data_bus_oe_n, o_low_address_data_bus});
      chk("latch", 16'h005A, 16'(o_latched_address));
      host.put(5'h04, 4'h0, 3'h3, 8'h00);
      chk("off", 16'h0101, {7'h00, o_port_a_oe_n, 7'h00, o_low_address_data_bus_oe_n});
      i_cfg_rw_select = 1'h1;
      host.put(5'h03, 4'h0, 3'h3, 8'h00);
      chk("enable read", 16'h0096, {7'h00, o_low_address_data_bus_oe_n, o_low_address_data_bus});
      i_cfg_rw_select = 1'h0;
      i_cfg_track_mode = 1'h0;
      $display("Track test done");
   endtask
   task automatic t_pd();
      i_cfg_term_en = '0;
      term(`PADEC_T_PORT, 16'h0100, 16'h0100);
      term(`PADEC_T_BANK, 16'h0000, 16'h0000);
      i_high_address_or_powerdown = 1'h1;
      host.put(5'h00, 4'h0, 3'h3, 8'h00);
      chk("port", 16'h0001, 16'(o_port_space_select));
      i_cfg_use_powerdown = 1'h1;
      host.put(5'h00, 4'h0, 3'h3, 8'h00);
      chk("standby", 16'hF000, {o_wide_external_selects_n, 4'h0, o_program_bank_selects});
      i_cfg_use_powerdown = 1'h0;
      i_rst = 1'h1;
      host.put(5'h00, 4'h0, 3'h3, 8'h00);
      chk("reset", 16'h0000, {o_latched_address, o_program_bank_selects});
      i_rst = 1'h0;
      host.put(5'h00, 4'h0, 3'h3, 8'h00);
      chk("release", 16'h0001, 16'(o_program_bank_selects));
      $display("Standby and reset test done");
   endtask
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge i_clk);
      #1;
      i_rst = 1'h0;
      t_sel();
      t_track();
      t_pd();
      summarize();
   end
endmodule // test_address_decode_chip_selects
